// ### dv/shpp_sva.sv
// pin checker for the host and device ends of the parallel port
// assumes one clock; instantiated beside the pin bundle, no bind
`timescale 1ns/1ps

module shpp_sva
(
  // clock and reset
  input wire logic                        clk,
  input wire logic                        sys_rst,
  // configuration
  input wire logic                        bus16,
  // pins
  input wire logic                        chip_select_n,
  input wire logic                        read_strobe_n,
  input wire logic                        write_strobe_n,
  input wire logic [shpp_pkg::ADDR_W-1:0] addr,
  input wire logic                        direct_port_select,
  input wire logic                        host_oe,
  input wire logic [shpp_pkg::DATA_W-1:0] dev_dout,
  input wire logic                        dev_oe_lo,
  input wire logic                        dev_oe_hi
);
  import shpp_pkg::*;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  logic              rd_q;
  logic [ADDR_W-1:0] addr_q;
  logic [5:0]        hold_q;
  wire               rd_act = !chip_select_n && !read_strobe_n;
  wire               wr_act = !chip_select_n && !write_strobe_n;
  // a new element: read start or a fresh address inside one
  wire               step   = rd_act && (!rd_q || addr != addr_q);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rd_q   <= 1'b0;
      addr_q <= '0;
      hold_q <= 6'h00;
    end
    else
    begin
      rd_q   <= rd_act;
      addr_q <= addr;
      hold_q <= !rd_act ? 6'h00 : step ? 6'h01 : hold_q + 6'h01;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_upper_float: assert property (bus16 |-> !dev_oe_hi)
    else $error("upper lanes driven in 16-bit mode");
  chk_oe_released: assert property (!rd_act && !rd_q |-> !dev_oe_lo && !dev_oe_hi)
    else $error("data bus driven outside a read");
  chk_oe_driven: assert property (rd_act[*4] |-> dev_oe_lo && (bus16 || dev_oe_hi))
    else $error("data bus not driven during a read");
  chk_no_fight: assert property (!(host_oe && (dev_oe_lo || dev_oe_hi)))
    else $error("both ends drive the data bus");
  chk_gap_len: assert property (rd_q && !rd_act |=> !rd_act)
    else $error("strobe high time too short");
  chk_elem_hold: assert property (hold_q != 6'h00 && (!rd_act || step) |-> hold_q >= 6'h11)
    else $error("read element shorter than cycle time");
  chk_burst_step: assert property (rd_act && rd_q && addr != addr_q
                                   |-> addr == addr_q + (bus16 ? 7'h01 : 7'h02))
    else $error("burst address step wrong");
  chk_wr_qualify: assert property (wr_act |-> host_oe && read_strobe_n)
    else $error("write cycle without host data");
  chk_dout_steady: assert property ((rd_act && !step)[*4] |-> $stable(dev_dout))
    else $error("read data moved within an element");

  cov_direct: cover property (rd_act && direct_port_select && dev_oe_lo);
  cov_half:   cover property (bus16 && rd_act && dev_oe_lo);
  cov_burst:  cover property (rd_act && rd_q && addr != addr_q);
  cov_write:  cover property (wr_act && host_oe);
endmodule

// ### dv/sram_like_host_pio_port_tb.sv
// bench: host end and device end joined by the pin bundle
// assumes the hand-over timing of both ends; the bench models the csr file
`timescale 1ns/1ps

module sram_like_host_pio_port_tb;
  import shpp_pkg::*;

  logic               clk, sys_rst, bus16, rxd_valid, rxd_ready, rxs_valid, txs_valid;
  logic               cmd_valid, cmd_ready, cmd_write, cmd_direct, rsp_valid, done;
  logic               rxs_pop, txs_pop, csr_rd_stb, wr_stb, wr_direct;
  logic [BADDR_W-1:0] cmd_addr, csr_rd_addr, wr_addr;
  logic [LEN_W-1:0]   cmd_len;
  logic [DATA_W-1:0]  cmd_wdata, rxd_data, rxs_data, txs_data, csr_rd_data, rsp_data, wr_data;
  logic [DATA_W-1:0]  rxq[$], expq[$];
  logic [40:0]        wrq[$];
  int                 fails, n_tests;

  // ----------------------------------------------------------------------
  // ends, bundle and checker
  // ----------------------------------------------------------------------
  function automatic logic [31:0] csr_val(input logic [7:0] b);
    return {8'h5A, 2'h0, b[7:2], 8'hC3, 2'h0, b[7:2]};
  endfunction
  assign csr_rd_data = csr_val(csr_rd_addr);

  shpp_if shpp_if_i ();
  shpp_dev shpp_dev_i (.clk, .sys_rst, .pins(shpp_if_i.dev), .bus16, .rxd_valid, .rxd_ready,
    .rxd_data, .rxs_valid, .rxs_data, .rxs_pop, .txs_valid, .txs_data, .txs_pop, .csr_rd_addr,
    .csr_rd_stb, .csr_rd_data, .wr_stb, .wr_direct, .wr_addr, .wr_data);
  shpp_host shpp_host_i (.clk, .sys_rst, .pins(shpp_if_i.host), .bus16, .cmd_valid,
    .cmd_ready, .cmd_write, .cmd_direct, .cmd_addr, .cmd_len, .cmd_wdata, .rsp_valid,
    .rsp_data, .done);
  shpp_sva shpp_sva_i (.clk, .sys_rst, .bus16, .chip_select_n(shpp_if_i.chip_select_n),
    .read_strobe_n(shpp_if_i.read_strobe_n), .write_strobe_n(shpp_if_i.write_strobe_n),
    .addr(shpp_if_i.addr), .direct_port_select(shpp_if_i.direct_port_select),
    .host_oe(shpp_if_i.host_oe), .dev_dout(shpp_if_i.dev_dout),
    .dev_oe_lo(shpp_if_i.dev_oe_lo), .dev_oe_hi(shpp_if_i.dev_oe_hi));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------------
  // checking and expectations
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [40:0] seen, input logic [40:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // one element read; rx words leave only on a full-word or high-half read
  function automatic logic [31:0] exp_rd(input logic [7:0] a, input logic dir);
    logic [31:0] w;
    w = csr_val(a);
    if (dir || a < 8'h20)
    begin
      w = (rxq.size() > 0) ? rxq[0] : EMPTY_WORD;
      if ((!bus16 || a[1]) && rxq.size() > 0)
        void'(rxq.pop_front());
    end
    else if (a == RXS_OFS)
      w = rxs_data;
    else if (a == TXS_OFS)
      w = txs_data;
    return bus16 ? {16'h0000, a[1] ? w[31:16] : w[15:0]} : w;
  endfunction

  always @(posedge clk)
  begin
    if (!sys_rst && rsp_valid === 1'b1)
      check("rsp_data", rsp_data, expq.size() ? expq.pop_front() : 'x);
    if (!sys_rst && wr_stb === 1'b1)
      check("write", {wr_direct, wr_addr, wr_data},
            wrq.size() ? wrq.pop_front() : 'x);
    if (!sys_rst && (rxs_pop || txs_pop) === 1'b1)
      check("status pop", csr_rd_addr, rxs_pop ? RXS_OFS : TXS_OFS);
    if (!sys_rst && csr_rd_stb === 1'b1)
      check("csr_rd_stb", shpp_if_i.direct_port_select || csr_rd_addr < 8'h20, 1'b0);
  end

  // ----------------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------------
  task automatic run(input logic wr, input logic dir, input logic [7:0] a,
                     input logic [5:0] len, input logic [31:0] wd);
    int n;
    n = (len == 0 || wr) ? 1 : len;
    if (!dir && n > (bus16 ? 16 : 8))
      n = bus16 ? 16 : 8;
    if (wr)
      wrq.push_back({dir, a & 8'hFE, bus16 ? {16'h0000, wd[15:0]} : wd});
    else
      for (int i = 0; i < n; i++)
        expq.push_back(exp_rd((a & 8'hFE) + 8'(i * (bus16 ? 2 : 4)), dir));
    @(negedge clk);
    check("cmd_ready", cmd_ready, 1'b1);
    cmd_valid = 1'b1;
    {cmd_write, cmd_direct, cmd_addr, cmd_len, cmd_wdata} = {wr, dir, a, len, wd};
    @(negedge clk);
    cmd_valid = 1'b0;
    repeat (1200)
      if (done !== 1'b1)
        @(negedge clk);
    check("pending", expq.size() + wrq.size(), 0);
  endtask

  task automatic fill(input int n);
    repeat (n)
    begin
      @(negedge clk);
      rxd_valid = 1'b1;
      rxd_data = $urandom;
      // ready is settled here, before the edge that pushes
      if (rxd_ready)
        rxq.push_back(rxd_data);
      @(posedge clk);
    end
    @(negedge clk);
    rxd_valid = 1'b0;
  endtask

  initial
  begin
    repeat (10000) @(posedge clk);
    fails++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    {sys_rst, bus16, cmd_valid, rxd_valid, rxs_valid, txs_valid} = 6'h20;
    {cmd_write, cmd_direct, cmd_addr, cmd_len, cmd_wdata} = '0;
    {rxd_data, rxs_data, txs_data} = '0;
    void'($urandom(32035));
    repeat (2) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    check("oe", {shpp_if_i.dev_oe_lo, shpp_if_i.dev_oe_hi, rxd_ready}, 3'h1);
    $display("test reset done");
    for (int m = 0; m < 2; m++)
    begin
      bus16 = m[0];
      {rxs_valid, txs_valid} = 2'h3;
      rxs_data = $urandom;
      txs_data = $urandom;
      repeat (3)
        run(1'b0, 1'b0, 8'h20 + 8'(4 * ($urandom % 8)), 6'h01, '0);
      if (!bus16)
        run(1'b0, 1'b0, RXS_OFS, 6'h03, '0);
      run(1'b0, 1'b0, 8'h50, 6'h14, '0);
      for (int w = 0; w < 3; w++)
        run(1'b1, w[0], 8'($urandom), 6'h01, $urandom);
      $display("test csr burst write mode %0d done", m);
      fill(FIFO_DEPTH + 4);
      check("fifo full", {rxq.size() == FIFO_DEPTH, rxd_ready}, 2'h2);
      run(1'b0, 1'b0, 8'h00, 6'h02, '0);
      run(1'b0, 1'b1, {6'($urandom), 2'h0},
          6'(rxq.size() * (bus16 ? 2 : 1) + 1), '0);
      $display("test fifo direct mode %0d done", m);
    end
    tally_and_finish();
  end
endmodule

// ### hw/shpp_dev.sv
// device end of the strobe-based parallel port plus its receive data fifo
// assumes pins already synchronous to clk and a host keeping the pin timing
//
// Contract
// R1 - reads reach registers, rx data, both status fifos
// R2 - counter snapshot taken at read start
// R3 - read runs while select and read low
// R4 - host gaps 13 ns, cycles 165 ns
// R5 - 16-bit mode leaves upper lanes undriven
// R6 - normal burst 8 words or 16 halfwords
// R7 - direct select reads rx data always
// R8 - direct reads use low bits, ignore upper
// R9 - direct select timed like the address
// R10 - direct bursts have no length limit
// R11 - after direct burst strobe stays high 13 ns
// R12 - writes qualified by select and write strobe
// R13 - 16-bit mode ignores upper lanes on writes
// R14 - 32-bit data bus, 16-bit option
// R15 - write runs while select and write low
// R16 - each new burst address steps the source
// R17 - data driven only during active read; enables are registered, so drive lags the strobe by one clock

`timescale 1ns/1ps

// --------------------------------------------------------------------------
// synchronous fifo
// --------------------------------------------------------------------------
module shpp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
)
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW:0]      wp_q;
  logic [PW:0]      rp_q;
  logic             push;
  logic             pop;

  assign out_valid = (wp_q != rp_q);
  assign in_ready  = (wp_q[PW-1:0] != rp_q[PW-1:0]) || (wp_q[PW] == rp_q[PW]);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rp_q[PW-1:0]];

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wp_q <= '0;
      rp_q <= '0;
    end
    else
    begin
      if (push)
        wp_q <= wp_q + 1'b1;
      if (pop)
        rp_q <= rp_q + 1'b1;
    end
  end

  // storage needs no reset; head is only read while valid
  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wp_q[PW-1:0]] <= in_data;
  end
endmodule

// --------------------------------------------------------------------------
// device end
// --------------------------------------------------------------------------
module shpp_dev
(
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  // pins
  shpp_if.dev                                pins,
  // configuration
  input  wire logic                          bus16,
  // receive data stream into the fifo
  input  wire logic                          rxd_valid,
  output logic                               rxd_ready,
  input  wire logic [shpp_pkg::DATA_W-1:0]   rxd_data,
  // receive and transmit status sources
  input  wire logic                          rxs_valid,
  input  wire logic [shpp_pkg::DATA_W-1:0]   rxs_data,
  output logic                               rxs_pop,
  input  wire logic                          txs_valid,
  input  wire logic [shpp_pkg::DATA_W-1:0]   txs_data,
  output logic                               txs_pop,
  // control and status register read port
  output logic [shpp_pkg::BADDR_W-1:0]       csr_rd_addr,
  output logic                               csr_rd_stb,
  input  wire logic [shpp_pkg::DATA_W-1:0]   csr_rd_data,
  // write port
  output logic                               wr_stb,
  output logic                               wr_direct,
  output logic [shpp_pkg::BADDR_W-1:0]       wr_addr,
  output logic [shpp_pkg::DATA_W-1:0]        wr_data
);
  import shpp_pkg::*;

  // ------------------------------------------------------------------------
  // fifo in the receive data path
  // ------------------------------------------------------------------------
  logic              f_valid;
  logic              f_ready;
  logic [DATA_W-1:0] f_data;

  shpp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) shpp_fifo_i
  (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (rxd_valid),
    .in_ready  (rxd_ready),
    .in_data   (rxd_data),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  // ------------------------------------------------------------------------
  // read decode
  // ------------------------------------------------------------------------
  logic                  rd_act;
  logic                  rd_act_q;
  logic [ADDR_W:0]       key_q;
  logic                  rd_step;
  logic                  rd_start;
  logic                  last_half;
  logic                  pop_ok;
  logic [BADDR_W-1:0]    baddr;
  logic                  sel_rxd;
  logic                  sel_rxs;
  logic                  sel_txs;
  logic                  sel_cnt;
  logic                  sel_csr;
  logic [DATA_W-1:0]     cnt_q;
  logic [DATA_W-1:0]     snap_q;
  logic [DATA_W-1:0]     cnt_word;
  logic [DATA_W-1:0]     rd_word;
  logic [DATA_W-1:0]     dout_d;
  logic [DATA_W-1:0]     dout_q;
  logic                  oe_lo_q;
  logic                  oe_hi_q;

  assign rd_act   = !pins.chip_select_n && !pins.read_strobe_n;           // [R3]
  assign rd_start = rd_act && !rd_act_q;
  // a fresh address inside a held strobe is a new burst element
  assign rd_step  = rd_act && (!rd_act_q ||
                    key_q != {pins.direct_port_select, pins.addr});       // [R6] [R10] [R16]
  assign baddr    = {pins.addr, 1'b0};

  // direct select overrides the upper address decode
  assign sel_rxd = pins.direct_port_select || (baddr[7:5] == RXD_REGION); // [R7] [R8]
  assign sel_rxs = !sel_rxd && (baddr[7:2] == RXS_OFS[7:2]);              // [R1]
  assign sel_txs = !sel_rxd && (baddr[7:2] == TXS_OFS[7:2]);              // [R1]
  assign sel_cnt = !sel_rxd && (baddr[7:2] == CNT_OFS[7:2]);
  assign sel_csr = !sel_rxd && !sel_rxs && !sel_txs && !sel_cnt;

  // halfword reads consume an element only on the upper half
  assign last_half = !bus16 || baddr[1];                                 // [R14]
  assign pop_ok    = rd_step && last_half;

  // counter is frozen for the whole cycle once the read starts
  assign cnt_word  = rd_act_q ? snap_q : cnt_q;                           // [R2]

  assign rd_word = sel_rxd ? (f_valid ? f_data : EMPTY_WORD) :
                   sel_rxs ? rxs_data :
                   sel_txs ? txs_data :
                   sel_cnt ? cnt_word : csr_rd_data;                      // [R1]
  assign dout_d  = !bus16    ? rd_word :
                   baddr[1]  ? {16'h0000, rd_word[DATA_W-1:HALF_W]} :
                               {16'h0000, rd_word[HALF_W-1:0]};           // [R5]

  assign f_ready     = pop_ok && sel_rxd;                                 // [R16]
  assign rxs_pop     = pop_ok && sel_rxs && rxs_valid;
  assign txs_pop     = pop_ok && sel_txs && txs_valid;
  assign csr_rd_addr = baddr;
  assign csr_rd_stb  = rd_step && sel_csr;

  assign pins.dev_dout  = dout_q;
  assign pins.dev_oe_lo = oe_lo_q;
  assign pins.dev_oe_hi = oe_hi_q;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rd_act_q <= 1'b0;
      key_q    <= '0;
      cnt_q    <= '0;
      snap_q   <= '0;
      dout_q   <= '0;
      oe_lo_q  <= 1'b0;
      oe_hi_q  <= 1'b0;
    end
    else
    begin
      rd_act_q <= rd_act;
      key_q    <= {pins.direct_port_select, pins.addr};
      cnt_q    <= cnt_q + 1'b1;
      if (rd_start)
        snap_q <= cnt_q;                                                  // [R2]
      if (rd_step)
        dout_q <= dout_d;
      oe_lo_q  <= rd_act;                                                 // [R17]
      oe_hi_q  <= rd_act && !bus16;                                       // [R5] [R17]
    end
  end

  // ------------------------------------------------------------------------
  // write capture
  // ------------------------------------------------------------------------
  logic                wr_act;
  logic                wr_act_q;
  logic                wr_stb_q;
  logic                wr_dir_q;
  logic [BADDR_W-1:0]  waddr_q;
  logic [DATA_W-1:0]   wdata_q;

  assign wr_act    = !pins.chip_select_n && !pins.write_strobe_n;         // [R12] [R15]
  assign wr_stb    = wr_stb_q;
  assign wr_direct = wr_dir_q;
  assign wr_addr   = waddr_q;
  assign wr_data   = wdata_q;

  // data is only good just before release, so keep sampling while held
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wr_act_q <= 1'b0;
      wr_stb_q <= 1'b0;
      wr_dir_q <= 1'b0;
      waddr_q  <= '0;
      wdata_q  <= '0;
    end
    else
    begin
      wr_act_q <= wr_act;
      wr_stb_q <= wr_act_q && !wr_act;                                    // [R15]
      if (wr_act)
      begin
        wr_dir_q <= pins.direct_port_select;
        waddr_q  <= baddr;
        wdata_q  <= bus16 ? {16'h0000, pins.bus[HALF_W-1:0]} : pins.bus;  // [R13]
      end
    end
  end
endmodule

// ### hw/shpp_host.sv
// host end: turns simple commands into strobe cycles on the parallel port
// assumes the device answers within one address cycle time

`timescale 1ns/1ps

module shpp_host
(
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  // pins
  shpp_if.host                               pins,
  // configuration
  input  wire logic                          bus16,
  // command
  input  wire logic                          cmd_valid,
  output logic                               cmd_ready,
  input  wire logic                          cmd_write,
  input  wire logic                          cmd_direct,
  input  wire logic [shpp_pkg::BADDR_W-1:0]  cmd_addr,
  input  wire logic [shpp_pkg::LEN_W-1:0]    cmd_len,
  input  wire logic [shpp_pkg::DATA_W-1:0]   cmd_wdata,
  // response
  output logic                               rsp_valid,
  output logic [shpp_pkg::DATA_W-1:0]        rsp_data,
  output logic                               done
);
  import shpp_pkg::*;

  shpp_host_st_t       st_q;
  logic [4:0]          cnt_q;
  logic [LEN_W-1:0]    left_q;
  logic                wr_q;
  logic                cs_n_q;
  logic                rd_n_q;
  logic                wr_n_q;
  logic                dir_q;
  logic [BADDR_W-1:0]  addr_q;
  logic [DATA_W-1:0]   dout_q;
  logic                rsp_valid_q;
  logic [DATA_W-1:0]   rsp_data_q;
  logic                done_q;
  logic [LEN_W-1:0]    len_max;
  logic [LEN_W-1:0]    len_one;
  logic [LEN_W-1:0]    len_use;
  logic [BADDR_W-1:0]  step;
  logic                hold_end;

  // ------------------------------------------------------------------------
  // command shaping
  // ------------------------------------------------------------------------
  assign len_max  = bus16 ? BURST_MAX_16 : BURST_MAX_32;
  assign len_one  = (cmd_len == '0 || cmd_write) ? 6'h01 : cmd_len;
  // direct fifo bursts run to any length, normal bursts are clamped
  assign len_use  = (!cmd_direct && len_one > len_max) ? len_max : len_one; // [R6] [R10]
  assign step     = bus16 ? STEP_16 : STEP_32;
  assign hold_end = (cnt_q == '0);

  assign cmd_ready           = (st_q == SHPP_IDLE);
  assign pins.chip_select_n  = cs_n_q;
  assign pins.read_strobe_n  = rd_n_q;
  assign pins.write_strobe_n = wr_n_q;
  assign pins.addr           = addr_q[BADDR_W-1:1];
  assign pins.direct_port_select = dir_q;                                 // [R9]
  assign pins.host_dout      = dout_q;
  assign pins.host_oe        = (st_q == SHPP_ACC) && wr_q;
  assign rsp_valid           = rsp_valid_q;
  assign rsp_data            = rsp_data_q;
  assign done                = done_q;

  // ------------------------------------------------------------------------
  // cycle sequencer
  // ------------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q        <= SHPP_IDLE;
      cnt_q       <= '0;
      left_q      <= '0;
      wr_q        <= 1'b0;
      cs_n_q      <= 1'b1;
      rd_n_q      <= 1'b1;
      wr_n_q      <= 1'b1;
      dir_q       <= 1'b0;
      addr_q      <= '0;
      dout_q      <= '0;
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= '0;
      done_q      <= 1'b0;
    end
    else
    begin
      rsp_valid_q <= 1'b0;
      done_q      <= 1'b0;
      case (st_q)
        SHPP_IDLE:
        begin
          if (cmd_valid)
          begin
            st_q   <= SHPP_ACC;
            cnt_q  <= HOLD_CNT;                                           // [R4]
            left_q <= len_use;
            wr_q   <= cmd_write;
            cs_n_q <= 1'b0;
            rd_n_q <= cmd_write;                                          // [R3]
            wr_n_q <= !cmd_write;                                         // [R12] [R15]
            dir_q  <= cmd_direct;                                         // [R9]
            addr_q <= cmd_addr;
            dout_q <= bus16 ? {16'h0000, cmd_wdata[HALF_W-1:0]} : cmd_wdata; // [R13]
          end
        end
        SHPP_ACC:
        begin
          cnt_q <= cnt_q - 1'b1;
          if (hold_end)
          begin
            if (!wr_q)
            begin
              rsp_valid_q <= 1'b1;
              rsp_data_q  <= bus16 ? {16'h0000, pins.bus[HALF_W-1:0]} : pins.bus;
            end
            if (left_q > 6'h01)
            begin
              left_q <= left_q - 1'b1;
              addr_q <= addr_q + step;                                    // [R16]
              cnt_q  <= HOLD_CNT;
            end
            else
            begin
              st_q   <= SHPP_GAP;
              cnt_q  <= GAP_CNT;                                          // [R4] [R11]
              cs_n_q <= 1'b1;
              rd_n_q <= 1'b1;
              wr_n_q <= 1'b1;
            end
          end
        end
        SHPP_GAP:
        begin
          cnt_q <= cnt_q - 1'b1;
          if (hold_end)
          begin
            st_q   <= SHPP_IDLE;
            done_q <= 1'b1;
          end
        end
        default:
        begin
          st_q <= SHPP_IDLE;
        end
      endcase
    end
  end
endmodule

// ### hw/shpp_if.sv
// pin bundle between the host and the device end of the parallel port
// resolves the shared data bus from the two sides' enables; no tristate

`timescale 1ns/1ps

interface shpp_if;
  import shpp_pkg::*;

  logic                chip_select_n;
  logic                read_strobe_n;
  logic                write_strobe_n;
  logic [ADDR_W-1:0]   addr;
  logic                direct_port_select;
  logic [DATA_W-1:0]   host_dout;
  logic                host_oe;
  logic [DATA_W-1:0]   dev_dout;
  logic                dev_oe_lo;
  logic                dev_oe_hi;
  logic [DATA_W-1:0]   bus;

  // undriven lanes read as ones, so a missing drive never looks like empty data
  assign bus[HALF_W-1:0] = dev_oe_lo ? dev_dout[HALF_W-1:0] :
                           host_oe   ? host_dout[HALF_W-1:0] : 16'hFFFF;
  assign bus[DATA_W-1:HALF_W] = dev_oe_hi ? dev_dout[DATA_W-1:HALF_W] :
                                host_oe   ? host_dout[DATA_W-1:HALF_W] : 16'hFFFF;

  modport dev
  (
    input  chip_select_n, read_strobe_n, write_strobe_n, addr, direct_port_select, bus,
    output dev_dout, dev_oe_lo, dev_oe_hi
  );

  modport host
  (
    output chip_select_n, read_strobe_n, write_strobe_n, addr, direct_port_select,
    output host_dout, host_oe,
    input  bus
  );
endinterface

// ### hw/shpp_pkg.sv
// shared constants and types for the strobe-based host parallel port
// assumes a single 100 MHz clock on both ends and synchronous pin sampling

package shpp_pkg;

  // ----------------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------------
  localparam int DATA_W      = 32;
  localparam int HALF_W      = 16;
  localparam int ADDR_W      = 7;
  localparam int BADDR_W     = 8;
  localparam int FIFO_DEPTH  = 16;
  localparam int LEN_W       = 6;

  // ----------------------------------------------------------------------
  // timing, printed figures and derived cycle counts
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_CYCLE_NS    = 165;
  localparam int T_CSL_NS      = 32;
  localparam int T_CSH_NS      = 13;
  localparam int T_ACYC_NS     = 165;
  localparam int CYCLE_CYC = (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CSL_CYC   = (T_CSL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CSH_CYC   = (T_CSH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACYC_CYC  = (T_ACYC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC  = (ACYC_CYC > CSL_CYC) ? ACYC_CYC : CSL_CYC;
  localparam logic [4:0] HOLD_CNT = 5'(HOLD_CYC - 1);
  localparam logic [4:0] GAP_CNT  = 5'(CSH_CYC - 1);

  // ----------------------------------------------------------------------
  // burst limits
  // ----------------------------------------------------------------------
  localparam logic [LEN_W-1:0] BURST_MAX_32 = 6'h08;
  localparam logic [LEN_W-1:0] BURST_MAX_16 = 6'h10;

  // ----------------------------------------------------------------------
  // address map, byte addresses
  // ----------------------------------------------------------------------
  localparam logic [2:0]         RXD_REGION = 3'h0;
  localparam logic [2:0]         TXD_REGION = 3'h1;
  localparam logic [BADDR_W-1:0] RXS_OFS    = 8'h40;
  localparam logic [BADDR_W-1:0] TXS_OFS    = 8'h48;
  localparam logic [BADDR_W-1:0] CNT_OFS    = 8'h7C;
  localparam logic [BADDR_W-1:0] STEP_32    = 8'h04;
  localparam logic [BADDR_W-1:0] STEP_16    = 8'h02;
  localparam logic [DATA_W-1:0]  EMPTY_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {
    SHPP_IDLE,
    SHPP_ACC,
    SHPP_GAP
  } shpp_host_st_t;

endpackage
